// [design/rstic_pkg.sv]
// Constants and carrier types for the reset and interrupt control block.
// Assumes a single 250 MHz clock and a byte-addressed Avalon-MM slave port.
package rstic_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [15:0] IDX_PIN_FUNC = 16'hffeb;
  localparam logic [15:0] IDX_EDGE_SEL = 16'hfff2;
  localparam logic [15:0] IDX_EXT_EN = 16'hfff3;
  localparam logic [15:0] IDX_INT_EN_A = 16'hfff4;
  localparam logic [15:0] IDX_INT_EN_B = 16'hfff5;
  localparam logic [15:0] IDX_EXT_PEND = 16'hfff6;
  localparam logic [15:0] IDX_INT_PEND_A = 16'hfff7;
  localparam logic [15:0] IDX_INT_PEND_B = 16'hfff8;

  // Values after reset
  localparam logic [7:0] RST_PIN_FUNC = 8'h00;
  localparam logic [7:0] RST_EDGE_SEL = 8'hec;
  localparam logic [7:0] RST_EXT_EN = 8'hc0;
  localparam logic [7:0] RST_INT_EN_A = 8'h00;
  localparam logic [7:0] RST_INT_EN_B = 8'h3c;
  localparam logic [7:0] RST_EXT_PEND = 8'hc0;
  localparam logic [7:0] RST_INT_PEND_A = 8'h00;
  localparam logic [7:0] RST_INT_PEND_B = 8'h3c;

  // Writable bits; the others are reserved and keep their reset value
  localparam logic [7:0] WM_PIN_FUNC = 8'hff;
  localparam logic [7:0] WM_EDGE_SEL = 8'h13;
  localparam logic [7:0] WM_EXT = 8'h3f;
  localparam logic [7:0] WM_INT_A = 8'hff;
  localparam logic [7:0] WM_INT_B = 8'hc3;

  // Field positions in the pin function register
  localparam int FILTER_BIT = 7;

  // Reset vector word address
  localparam logic [15:0] RESET_VEC_ADDR = 16'h0000;

  // Filter sampling interval, in states (clock cycles)
  localparam int FILTER_STATES = 256;
  localparam int FILTER_CYCLES = FILTER_STATES;

  // Source numbering for the accepted interrupt
  localparam logic [4:0] SRC_INT_A_BASE = 5'h06;
  localparam logic [4:0] SRC_INT_B_BASE = 5'h0e;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_FETCH = 2'b01,
    ST_RUN = 2'b10
  } rstic_state_t;

  // Requests and answers toward the CPU core
  typedef struct packed {
    logic halt;
    logic vec_req;
    logic [15:0] vec_addr;
    logic pc_load;
    logic [15:0] program_counter;
    logic int_accept;
    logic [4:0] int_source;
    logic global_mask;
  } rstic_cpu_out_t;

  // Events from the CPU core
  typedef struct packed {
    logic vec_valid;
    logic [15:0] vec_data;
    logic insn_done;
    logic mask_set;
    logic mask_clr;
  } rstic_cpu_in_t;

endpackage

// [design/rstic_top.sv]
// Reset sequencing, interrupt flags, enables and priority arbitration.
// Assumes all inputs synchronous to clk; the CPU answers a vector request
// with vec_valid and acknowledges nothing else.
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/1ps

// Summary of operation
// RL1: Reset sequence overrides any interrupt acceptance.
// RL2: Low reset pin halts and reinitialises everything. The code keeps the bus handshake, pin history and filter state.
// RL3: Entering reset sets the global interrupt mask.
// RL4: On pin rise fetch vector word zero.
// RL5: Party holds reset pin low ten cycles.
// RL6: Interrupts accepted only at instruction boundaries.
// RL7: Highest priority pending source served first.
// RL8: Mask set: flags still set, none accepted.
// RL9: Inputs 4,1,0 selectable; 5,3,2 falling only.
// RL10: Pending flags cleared by zero, one ignored.
// RL11: Eight-bit pin function register, bits 5-0.
// RL12: Bit 7 switches input 0 noise filter.
// RL13: Software disables interrupt before pin switch.
// RL14: Software waits one instruction before clearing.
// RL15: Edge select zero falling, one rising.
// RL16: Filter samples every 256 states, agreement needed.
// RL17: Enable bit passes or blocks its flag.
// RL18: Flags set only for pins in interrupt use.
module rstic_top
  import rstic_pkg::*;
#(
  parameter int ADDR_W = 18
)
(
  // Clock and synchronous reset
  input wire logic clk,
  input wire logic rst,
  // Reset pin, active low
  input wire logic hw_reset_in_n,
  // External interrupt pins, port 1 bits 5 to 0
  input wire logic [5:0] ext_int_inputs,
  // Internal peripheral requests, one-cycle pulses
  input wire logic [7:0] int_req_a,
  input wire logic [7:0] int_req_b,
  // CPU core side
  input wire rstic_cpu_in_t cpu_in,
  output rstic_cpu_out_t cpu_out,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Level interrupt, any enabled flag set
  output logic irq
);

  // Whole state of the block
  typedef struct packed {
    rstic_state_t state;
    logic [7:0] pin_func;
    logic [7:0] edge_sel;
    logic [7:0] ext_en;
    logic [7:0] int_en_a;
    logic [7:0] int_en_b;
    logic [7:0] ext_pend;
    logic [7:0] int_pend_a;
    logic [7:0] int_pend_b;
    logic [5:0] pin_prev;
    logic [7:0] div_cnt;
    logic samp_a;
    logic filt0;
    logic ack;
    logic [31:0] rdata;
    rstic_cpu_out_t cpu;
  } rstic_st_t;

  rstic_st_t st_r; // Registered state
  rstic_st_t st_nxt; // Next state

  logic [15:0] req_idx; // Register index of the bus access
  logic addr_ok; // Address is word aligned and within the index range
  logic take; // Bus access completes this cycle
  logic [5:0] lvl; // Pin levels after the filter
  logic [5:0] ext_edge; // Selected edges on interrupt-mode pins
  logic [5:0] ext_act; // Enabled external flags
  logic [7:0] act_a; // Enabled internal flags, group a
  logic [7:0] act_b; // Enabled internal flags, group b
  logic any_act; // Any enabled flag set
  logic [4:0] best_src; // Highest priority enabled source
  logic div_tick; // One-cycle enable every sampling interval

  // Writes a read-write register, keeping reserved bits at reset value
  function automatic logic [7:0] rw_merge(input logic [7:0] wd, input logic [7:0] wm, input logic [7:0] rv);
    rw_merge = (wd & wm) | (rv & ~wm);
  endfunction

  // Clears flags written as zero, then lets new events win over the clear
  function automatic logic [7:0] wc_merge(input logic [7:0] old, input logic [7:0] clr_keep, input logic [7:0] set);
    wc_merge = (old & clr_keep) | set;
  endfunction

  // Lowest set bit index of a byte, with a found flag in bit 3
  function automatic logic [3:0] lowest(input logic [7:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 7; i >= 0; i--)
    begin
      if (v[i])
      begin
        r = {1'b1, 3'(i)};
      end
    end
    lowest = r;
  endfunction

  // Bus decode; the index is the byte address divided by four
  assign req_idx = 16'(avs_address >> 2);
  assign addr_ok = (avs_address[1:0] == 2'b00) && ((avs_address >> 2) <= ADDR_W'(16'hffff));
  assign take = (avs_read || avs_write) && st_r.ack;
  assign avs_waitrequest = (avs_read || avs_write) && !st_r.ack;
  assign avs_readdata = st_r.rdata;

  // Sampling divider for the noise filter
  assign div_tick = (st_r.div_cnt == 8'(FILTER_CYCLES - 1));

  // Pin levels; input 0 may pass through the filter
  always_comb
  begin
    lvl = ext_int_inputs;
    if (st_r.pin_func[FILTER_BIT])
    begin
      lvl[0] = st_r.filt0; // [RL12]
    end
  end

  // Edge detection per pin; only writable select bits can pick rising
  always_comb
  begin
    logic [7:0] sel;
    sel = st_r.edge_sel & WM_EDGE_SEL; // [RL9]
    for (int i = 0; i < 6; i++)
    begin
      if (sel[i])
      begin
        ext_edge[i] = lvl[i] && !st_r.pin_prev[i]; // [RL15]
      end
      else
      begin
        ext_edge[i] = !lvl[i] && st_r.pin_prev[i]; // [RL15]
      end
    end
    ext_edge = ext_edge & st_r.pin_func[5:0]; // [RL18]
  end

  // Enable gating of the flags
  assign ext_act = st_r.ext_pend[5:0] & st_r.ext_en[5:0]; // [RL17]
  assign act_a = st_r.int_pend_a & st_r.int_en_a;
  assign act_b = st_r.int_pend_b & st_r.int_en_b & WM_INT_B;
  assign any_act = (|ext_act) || (|act_a) || (|act_b);
  assign irq = any_act;

  // Priority: external pins 0 to 5 first, lowest pin first, then group a, then group b
  always_comb
  begin
    logic [3:0] pe;
    logic [3:0] pa;
    logic [3:0] pb;
    pe = lowest({2'b00, ext_act});
    pa = lowest(act_a);
    pb = lowest(act_b);
    if (pe[3])
    begin
      best_src = {2'b00, pe[2:0]}; // [RL7]
    end
    else if (pa[3])
    begin
      best_src = SRC_INT_A_BASE + {2'b00, pa[2:0]}; // [RL7]
    end
    else
    begin
      best_src = SRC_INT_B_BASE + {2'b00, pb[2:0]}; // [RL7]
    end
  end

  // Next state of the whole block
  always_comb
  begin
    logic [7:0] wd;
    logic [7:0] keep_e;
    logic [7:0] keep_a;
    logic [7:0] keep_b;
    wd = avs_writedata[7:0];
    keep_e = 8'hff;
    keep_a = 8'hff;
    keep_b = 8'hff;
    st_nxt = st_r;

    // Bus handshake: one wait cycle, then the answer
    st_nxt.ack = (avs_read || avs_write) && !st_r.ack;
    if (avs_read && !st_r.ack)
    begin
      st_nxt.rdata = 32'h0000_0000;
      if (addr_ok)
      begin
        case (req_idx)
          IDX_PIN_FUNC: st_nxt.rdata[7:0] = st_r.pin_func;
          IDX_EDGE_SEL: st_nxt.rdata[7:0] = st_r.edge_sel;
          IDX_EXT_EN: st_nxt.rdata[7:0] = st_r.ext_en;
          IDX_INT_EN_A: st_nxt.rdata[7:0] = st_r.int_en_a;
          IDX_INT_EN_B: st_nxt.rdata[7:0] = st_r.int_en_b;
          IDX_EXT_PEND: st_nxt.rdata[7:0] = st_r.ext_pend;
          IDX_INT_PEND_A: st_nxt.rdata[7:0] = st_r.int_pend_a;
          IDX_INT_PEND_B: st_nxt.rdata[7:0] = st_r.int_pend_b;
          default: st_nxt.rdata = 32'h0000_0000;
        endcase
      end
    end

    // Register writes at the completing edge
    if (take && avs_write && addr_ok)
    begin
      case (req_idx)
        IDX_PIN_FUNC: st_nxt.pin_func = rw_merge(wd, WM_PIN_FUNC, RST_PIN_FUNC); // [RL11]
        IDX_EDGE_SEL: st_nxt.edge_sel = rw_merge(wd, WM_EDGE_SEL, RST_EDGE_SEL);
        IDX_EXT_EN: st_nxt.ext_en = rw_merge(wd, WM_EXT, RST_EXT_EN);
        IDX_INT_EN_A: st_nxt.int_en_a = rw_merge(wd, WM_INT_A, RST_INT_EN_A);
        IDX_INT_EN_B: st_nxt.int_en_b = rw_merge(wd, WM_INT_B, RST_INT_EN_B);
        IDX_EXT_PEND: keep_e = wd | ~WM_EXT; // [RL10]
        IDX_INT_PEND_A: keep_a = wd | ~WM_INT_A; // [RL10]
        IDX_INT_PEND_B: keep_b = wd | ~WM_INT_B; // [RL10]
        default: keep_e = 8'hff;
      endcase
    end

    // Flags are set even while masked; set beats a same-cycle clear
    st_nxt.ext_pend = wc_merge(st_r.ext_pend, keep_e, {2'b00, ext_edge}); // [RL8]
    st_nxt.int_pend_a = wc_merge(st_r.int_pend_a, keep_a, int_req_a & WM_INT_A); // [RL8]
    st_nxt.int_pend_b = wc_merge(st_r.int_pend_b, keep_b, int_req_b & WM_INT_B); // [RL8]
    st_nxt.pin_prev = lvl;

    // Noise filter: change only when two successive samples agree
    st_nxt.div_cnt = div_tick ? 8'h00 : st_r.div_cnt + 8'h01; // [RL16]
    if (div_tick)
    begin
      st_nxt.samp_a = ext_int_inputs[0];
      if (ext_int_inputs[0] == st_r.samp_a)
      begin
        st_nxt.filt0 = ext_int_inputs[0]; // [RL16]
      end
    end

    // CPU mask bit driven by the core
    if (cpu_in.mask_set)
    begin
      st_nxt.cpu.global_mask = 1'b1;
    end
    else if (cpu_in.mask_clr)
    begin
      st_nxt.cpu.global_mask = 1'b0;
    end

    // One-cycle pulses default low
    st_nxt.cpu.pc_load = 1'b0;
    st_nxt.cpu.int_accept = 1'b0;

    // Reset and interrupt sequencer
    case (st_r.state)
      ST_RESET:
      begin
        st_nxt.cpu.halt = 1'b1;
        if (hw_reset_in_n)
        begin
          st_nxt.state = ST_FETCH; // [RL4]
          st_nxt.cpu.vec_req = 1'b1; // [RL4]
          st_nxt.cpu.vec_addr = RESET_VEC_ADDR; // [RL4]
        end
      end
      ST_FETCH:
      begin
        if (cpu_in.vec_valid)
        begin
          st_nxt.state = ST_RUN;
          st_nxt.cpu.vec_req = 1'b0;
          st_nxt.cpu.pc_load = 1'b1; // [RL4]
          st_nxt.cpu.program_counter = cpu_in.vec_data; // [RL4]
          st_nxt.cpu.halt = 1'b0;
        end
      end
      ST_RUN:
      begin
        // Accept only at an instruction end and with the mask clear
        if (cpu_in.insn_done && !st_r.cpu.global_mask && any_act) // [RL6] [RL8]
        begin
          st_nxt.cpu.int_accept = 1'b1;
          st_nxt.cpu.int_source = best_src; // [RL7]
          st_nxt.cpu.global_mask = 1'b1;
        end
      end
      default:
      begin
        st_nxt.state = ST_RESET;
      end
    endcase

    // Low reset pin overrides everything except the bus handshake, the pin history and the noise filter state
    if (!hw_reset_in_n) // [RL1] [RL2]
    begin
      st_nxt.state = ST_RESET;
      st_nxt.pin_func = RST_PIN_FUNC; // [RL2]
      st_nxt.edge_sel = RST_EDGE_SEL;
      st_nxt.ext_en = RST_EXT_EN;
      st_nxt.int_en_a = RST_INT_EN_A;
      st_nxt.int_en_b = RST_INT_EN_B;
      st_nxt.ext_pend = RST_EXT_PEND;
      st_nxt.int_pend_a = RST_INT_PEND_A;
      st_nxt.int_pend_b = RST_INT_PEND_B;
      st_nxt.cpu = '0;
      st_nxt.cpu.halt = 1'b1; // [RL2]
      st_nxt.cpu.global_mask = 1'b1; // [RL3]
    end
  end

  // Register the state
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_r <= '0;
      st_r.state <= ST_RESET;
      st_r.pin_func <= RST_PIN_FUNC;
      st_r.edge_sel <= RST_EDGE_SEL;
      st_r.ext_en <= RST_EXT_EN;
      st_r.int_en_a <= RST_INT_EN_A;
      st_r.int_en_b <= RST_INT_EN_B;
      st_r.ext_pend <= RST_EXT_PEND;
      st_r.int_pend_a <= RST_INT_PEND_A;
      st_r.int_pend_b <= RST_INT_PEND_B;
      st_r.pin_prev <= 6'h3f;
      st_r.samp_a <= 1'b1;
      st_r.filt0 <= 1'b1;
      st_r.cpu.halt <= 1'b1;
      st_r.cpu.global_mask <= 1'b1; // [RL3]
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // CPU-side outputs come straight from flip-flops
  assign cpu_out = st_r.cpu;

endmodule // rstic_top

// [test/rstic_top_monitor.sv]
// Concurrent checks on the reset and interrupt control ports.
// Assumes it is bound into rstic_top and sees only its ports.
`timescale 1ns/1ps
module rstic_monitor
  import rstic_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Reset pin and CPU side
  input wire logic hw_reset_in_n,
  input wire rstic_cpu_in_t cpu_in,
  input wire rstic_cpu_out_t cpu_out,
  // Bus handshake
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest
);
  // One clock domain, reset silences every check
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_accept_at_boundary:
    assert property (cpu_out.int_accept |-> $past(cpu_in.insn_done) && !$past(cpu_out.global_mask))
    else $error("accept off a boundary or while masked");
  a_accept_masks_next:
    assert property (cpu_out.int_accept |-> cpu_out.global_mask) else $error("accept left mask open");
  a_mask_holds_set:
    assert property (cpu_out.global_mask && !cpu_in.mask_clr |=> cpu_out.global_mask)
    else $error("mask dropped without clear");
  a_pin_low_halts:
    assert property (!hw_reset_in_n |=> cpu_out.halt && cpu_out.global_mask && !cpu_out.int_accept)
    else $error("low reset pin did not halt");
  a_halt_blocks_accept:
    assert property (cpu_out.halt |-> !cpu_out.int_accept) else $error("accept during reset");
  a_rise_fetches_vector:
    assert property ($rose(hw_reset_in_n) |=> cpu_out.vec_req && cpu_out.vec_addr == 16'h0000)
    else $error("no vector fetch after pin rise");
  a_vector_loads_pc:
    assert property (cpu_out.vec_req && cpu_in.vec_valid && hw_reset_in_n |=>
      cpu_out.pc_load && !cpu_out.halt && cpu_out.program_counter == $past(cpu_in.vec_data))
    else $error("vector word not loaded");
  a_bus_first_wait:
    assert property ((avs_read || avs_write) && !$past(avs_read || avs_write) |-> avs_waitrequest)
    else $error("no wait state on first cycle");
  a_bus_one_wait:
    assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait state");
endmodule // rstic_monitor

bind rstic_top rstic_monitor i_mon (.clk(clk), .rst(rst), .hw_reset_in_n(hw_reset_in_n), .cpu_in(cpu_in),
  .cpu_out(cpu_out), .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest));

// [test/rstic_cpu_model.sv]
// Behavioural CPU core facing the reset and interrupt control block.
// Assumes the bench sets answer delay, vector word and mask clear pulses.
`timescale 1ns/1ps
module rstic_cpu_model
  import rstic_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Block side
  input wire rstic_cpu_out_t cpu_out,
  output rstic_cpu_in_t cpu_in,
  // Bench controls
  input wire logic [3:0] vec_delay,
  input wire logic [15:0] vector,
  input wire logic run_en,
  input wire logic clr_req
);
  logic [3:0] wait_r; // Cycles spent on the vector read
  logic tick_r; // Instructions end every other cycle

  // Count the vector read and the instruction rhythm
  always_ff @(posedge clk)
  begin
    if (rst || !cpu_out.vec_req) wait_r <= 4'h0;
    else if (wait_r != vec_delay) wait_r <= wait_r + 4'h1;
    tick_r <= rst ? 1'b0 : !tick_r;
  end

  // Answers; the data lines carry junk outside the valid cycle
  always_comb
  begin
    cpu_in.vec_valid = cpu_out.vec_req && (wait_r == vec_delay);
    cpu_in.vec_data = cpu_in.vec_valid ? vector : ~vector;
    cpu_in.insn_done = run_en && tick_r && !cpu_out.halt;
    cpu_in.mask_set = 1'b0;
    cpu_in.mask_clr = clr_req;
  end
endmodule // rstic_cpu_model

// [test/testbench.sv]
// Self-checking bench for the reset and interrupt control block.
// Assumes the CPU model and the bound checker sit beside the design.
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin errors++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module testbench
  import rstic_pkg::*;
;
  logic clk, rst, hw_reset_in_n, avs_read, avs_write, avs_waitrequest, irq;
  logic [5:0] ext_int_inputs;
  logic [7:0] int_req_a, int_req_b, rd;
  logic [17:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  rstic_cpu_in_t cpu_in;
  rstic_cpu_out_t cpu_out;
  logic [3:0] vec_delay;
  logic [15:0] vector;
  logic run_en, clr_req;
  int errors, compares;

  always #2 clk = ~clk;

  rstic_top i_dut (.clk(clk), .rst(rst), .hw_reset_in_n(hw_reset_in_n), .ext_int_inputs(ext_int_inputs),
    .int_req_a(int_req_a), .int_req_b(int_req_b), .cpu_in(cpu_in), .cpu_out(cpu_out),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));
  rstic_cpu_model i_cpu (.clk(clk), .rst(rst), .cpu_out(cpu_out), .cpu_in(cpu_in),
    .vec_delay(vec_delay), .vector(vector), .run_en(run_en), .clr_req(clr_req));

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic give_up();
    errors++;
    end_of_test();
  endtask

  // One Avalon transfer, held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
    int n;
    avs_address <= {idx, 2'b00};
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= {24'h00_0000, wd};
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (n == 20) give_up();
    rd = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask

  task automatic rd_chk(input logic [15:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    `CHK(rd, e)
  endtask

  // Wait for the program counter load after a pin release
  task automatic wait_load(input logic [15:0] v);
    int n;
    n = 0;
    do begin @(negedge clk); n++; end while (cpu_out.pc_load !== 1'b1 && n < 50);
    if (n == 50) give_up();
    `CHK(cpu_out.program_counter, v)
    `CHK(cpu_out.halt, 1'b0)
    `CHK(cpu_out.global_mask, 1'b1)
    @(posedge clk);
  endtask

  // Lift the mask and wait for the next accepted source
  task automatic accept(input logic [4:0] src);
    int n;
    clr_req <= 1'b1;
    @(posedge clk);
    clr_req <= 1'b0;
    n = 0;
    do begin @(negedge clk); n++; end while (cpu_out.int_accept !== 1'b1 && n < 40);
    if (n == 40) give_up();
    `CHK(cpu_out.int_source, src)
    @(posedge clk);
  endtask

  task automatic t_regs();
    logic [15:0] idx [9] = '{IDX_PIN_FUNC, IDX_EDGE_SEL, IDX_EXT_EN, IDX_INT_EN_A, IDX_INT_EN_B,
      IDX_EXT_PEND, IDX_INT_PEND_A, IDX_INT_PEND_B, 16'hfff9};
    logic [7:0] exp [9] = '{8'h00, 8'hec, 8'hc0, 8'h00, 8'h3c, 8'hc0, 8'h00, 8'h3c, 8'h00};
    for (int i = 0; i < 9; i++) rd_chk(idx[i], exp[i]);
    `CHK(cpu_out.halt, 1'b1)
    `CHK(cpu_out.global_mask, 1'b1)
    $display("Test registers done");
  endtask

  task automatic t_boot();
    repeat (10) @(posedge clk);
    hw_reset_in_n <= 1'b1;
    wait_load(16'h0a5c);
    $display("Test boot done");
  endtask

  task automatic t_edges();
    wr(IDX_EXT_EN, 8'h00);
    wr(IDX_EDGE_SEL, 8'h11);
    rd_chk(IDX_EDGE_SEL, 8'hfd);
    wr(IDX_PIN_FUNC, 8'h13);
    rd_chk(IDX_PIN_FUNC, 8'h13);
    wr(IDX_EXT_PEND, 8'h00);
    ext_int_inputs <= 6'h00;
    repeat (3) @(posedge clk);
    rd_chk(IDX_EXT_PEND, 8'hc2);
    ext_int_inputs <= 6'h3f;
    repeat (3) @(posedge clk);
    rd_chk(IDX_EXT_PEND, 8'hd3);
    wr(IDX_EXT_PEND, 8'hfd);
    rd_chk(IDX_EXT_PEND, 8'hd1);
    wr(IDX_EXT_PEND, 8'h00);
    rd_chk(IDX_EXT_PEND, 8'hc0);
    $display("Test edges done");
  endtask

  task automatic t_mask();
    int n;
    n = 0;
    wr(IDX_EXT_EN, 8'h12);
    wr(IDX_INT_EN_A, 8'h01);
    run_en <= 1'b1;
    int_req_a <= 8'h01;
    ext_int_inputs <= 6'h3d;
    @(posedge clk);
    int_req_a <= 8'h00;
    repeat (20) begin @(negedge clk); if (cpu_out.int_accept !== 1'b0) n++; end
    `CHK(n, 0)
    `CHK(irq, 1'b1)
    @(posedge clk);
    rd_chk(IDX_EXT_PEND, 8'hc2);
    accept(5'h01);
    wr(IDX_EXT_PEND, 8'hfd);
    accept(SRC_INT_A_BASE);
    wr(IDX_INT_PEND_A, 8'h00);
    @(negedge clk);
    `CHK(irq, 1'b0)
    @(posedge clk);
    run_en <= 1'b0;
    $display("Test mask and priority done");
  endtask

  task automatic t_pin_reset();
    hw_reset_in_n <= 1'b0;
    vec_delay <= 4'h0;
    vector <= 16'h3c40;
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK(cpu_out.halt, 1'b1)
    `CHK(cpu_out.global_mask, 1'b1)
    @(posedge clk);
    rd_chk(IDX_EXT_EN, RST_EXT_EN);
    repeat (6) @(posedge clk);
    hw_reset_in_n <= 1'b1;
    wait_load(16'h3c40);
    $display("Test pin reset done");
  endtask

  // Input 0 through the filter: a short glitch is ignored, a steady low is seen
  task automatic t_filter();
    wr(IDX_PIN_FUNC, 8'h81);
    wr(IDX_EXT_PEND, 8'h00);
    ext_int_inputs <= 6'h3c;
    repeat (200) @(posedge clk);
    ext_int_inputs <= 6'h3d;
    repeat (600) @(posedge clk);
    rd_chk(IDX_EXT_PEND, RST_EXT_PEND);
    ext_int_inputs <= 6'h3c;
    repeat (100) @(posedge clk);
    rd_chk(IDX_EXT_PEND, RST_EXT_PEND);
    repeat (420) @(posedge clk);
    rd_chk(IDX_EXT_PEND, 8'hc1);
    $display("Test noise filter done");
  endtask

  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    hw_reset_in_n = 1'b0;
    ext_int_inputs = 6'h3f;
    int_req_a = 8'h00;
    int_req_b = 8'h00;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    vec_delay = 4'h3;
    vector = 16'h0a5c;
    run_en = 1'b0;
    clr_req = 1'b0;
    errors = 0;
    compares = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_boot();
    t_edges();
    t_mask();
    t_pin_reset();
    t_filter();
    end_of_test();
  end
endmodule // testbench
